//--- sdfu_checker.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module sdfu_checker
  import sdfu_pkg::*;
#(
  parameter longint TICK_CYCLES = SDFU_TICK_CYCLES,
  parameter int OUT_WIDTH = 16
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Register read channel
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  // Sequencer
  input wire logic RUN_SWITCH_I,
  input wire logic STORED_PROGRAM_I,
  input wire logic ERASE_DONE_I,
  input wire logic PROGRAM_RUN_O,
  input wire logic ERASE_ALL_O,
  input wire logic ERASE_UNRETAINED_O,
  input wire logic LOAD_DEFAULTS_O,
  input wire logic LOAD_PROGRAM_O,
  input wire logic BUS_REINIT_O,
  input wire logic [OUT_WIDTH-1:0] PROCESS_OUT_O
);
  logic [7:0] rd_addr;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);

  ////////////////////////////////////////////////////////////////////////
  // Address of the read under way
  always_ff @(posedge CLOCK_I)
  begin
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      rd_addr <= S_AXI_ARADDR_I;
  end

  // Read path and flag word
  a_read_latency: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read answer late");
  a_sum_is_or: assert property ($rose(S_AXI_RVALID_O) &&
    rd_addr == SDFU_OFS_FLAG_PRIMARY
    |-> S_AXI_RDATA_O[10] == |S_AXI_RDATA_O[14:11])
    else $error("sum error differs from class flags");

  // Run switch
  a_stop_aborts: assert property (PROGRAM_RUN_O && !RUN_SWITCH_I
    |=> !PROGRAM_RUN_O) else $error("program kept running");
  a_stop_zeroes: assert property (!PROGRAM_RUN_O ##1 !PROGRAM_RUN_O
    |-> PROCESS_OUT_O == '0) else $error("outputs not zero in stop");
  a_start_on_switch: assert property ($rose(PROGRAM_RUN_O)
    |-> $past(RUN_SWITCH_I)) else $error("start without run switch");

  // Cold and warm start
  a_cold_holds: assert property (ERASE_ALL_O && !ERASE_DONE_I
    |=> ERASE_ALL_O) else $error("cold erase left early");
  a_cold_to_load: assert property (ERASE_ALL_O && ERASE_DONE_I
    |=> BUS_REINIT_O && LOAD_PROGRAM_O == STORED_PROGRAM_I
    && LOAD_DEFAULTS_O != STORED_PROGRAM_I)
    else $error("cold start load wrong");
  a_warm_holds: assert property (ERASE_UNRETAINED_O && !ERASE_DONE_I
    |=> ERASE_UNRETAINED_O) else $error("warm erase left early");
  a_warm_to_load: assert property (ERASE_UNRETAINED_O && ERASE_DONE_I
    |=> BUS_REINIT_O ##1 !BUS_REINIT_O) else $error("warm reinit wrong");
  a_reinit_once: assert property (BUS_REINIT_O
    |=> !BUS_REINIT_O && !PROGRAM_RUN_O) else $error("reinit not single");
endmodule : sdfu_checker

bind sdfu_top sdfu_checker #(.TICK_CYCLES(TICK_CYCLES),
  .OUT_WIDTH(OUT_WIDTH)) u_checker (.CLOCK_I, .SYS_RST_I, .S_AXI_ARADDR_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O,
  .RUN_SWITCH_I, .STORED_PROGRAM_I, .ERASE_DONE_I, .PROGRAM_RUN_O,
  .ERASE_ALL_O, .ERASE_UNRETAINED_O, .LOAD_DEFAULTS_O, .LOAD_PROGRAM_O,
  .BUS_REINIT_O, .PROCESS_OUT_O);

//--- sdfu_osc_gen.sv
`timescale 1ns/1ns
// Common time base and phase-related oscillator flags
module sdfu_osc_gen
  import sdfu_pkg::*;
#(
  parameter longint TICK_CYCLES = SDFU_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Oscillator outputs
  sdfu_osc_if.gen osc
);
  logic [31:0] pre;
  logic [9:0] ticks;
  logic [6:0] wave;
  logic tick;

  assign tick = (pre == 32'(TICK_CYCLES - 1));
  assign osc.tick = tick;
  assign osc.wave = wave;

  // Prescaler to a 16 Hz tick, then a shared tick counter
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      pre <= '0;
      ticks <= '0;
    end
    else
    begin
      pre <= tick ? '0 : pre + 32'h1;
      if (tick)
        ticks <= ticks + 10'h1;
    end
  end

  // Each flag toggles when its half period wraps, so all stay phased
  genvar g;
  generate
    for (g = 0; g < SDFU_OSC_COUNT; g++)
    begin : g_osc
      always_ff @(posedge CLOCK_I)
      begin
        if (SYS_RST_I)
          wave[g] <= 1'b0;
        else if (tick && (((ticks + 10'h1) & (SDFU_OSC_HALF[g] - 10'h1)) == 10'h0))
          wave[g] <= ~wave[g];
      end
    end
  endgenerate

endmodule : sdfu_osc_gen

//--- sdfu_osc_if.sv
`timescale 1ns/1ns
// Oscillator bank link between top and divider
interface sdfu_osc_if;
  logic tick;
  logic [6:0] wave;
  modport gen (output tick, output wave);
  modport use_side (input tick, input wave);
endinterface : sdfu_osc_if

//--- sdfu_pkg.sv
package sdfu_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] SDFU_OFS_FLAG_PRIMARY = 8'h00;
  localparam logic [7:0] SDFU_OFS_OSC_ALTERNATE = 8'h04;
  localparam logic [7:0] SDFU_OFS_DETAIL_FS = 8'h08;
  localparam logic [7:0] SDFU_OFS_DETAIL_LW = 8'h0C;
  localparam logic [7:0] SDFU_OFS_LOAD_PCT = 8'h10;
  localparam logic [7:0] SDFU_OFS_OVR_TASK = 8'h14;
  localparam logic [7:0] SDFU_OFS_OVR_LATE = 8'h18;
  localparam logic [7:0] SDFU_OFS_MISSED = 8'h1C;
  localparam logic [7:0] SDFU_OFS_BUS_STATUS = 8'h20;
  localparam logic [7:0] SDFU_OFS_CONFIG = 8'h24;
  localparam logic [7:0] SDFU_OFS_CONTROL = 8'h28;
  localparam logic [7:0] SDFU_OFS_MODE = 8'h2C;

  // Field positions in the primary flag word
  localparam int SDFU_BIT_NET_IRQ = 9;
  localparam int SDFU_BIT_SUM_ERR = 10;
  localparam int SDFU_BIT_FATAL = 11;
  localparam int SDFU_BIT_WARN = 14;
  localparam int SDFU_BIT_FIRST_CYCLE = 15;
  // Oscillator set select bit in the configuration word
  localparam int SDFU_BIT_OSC_SEL = 15;
  localparam int SDFU_OSC_COUNT = 7;

  // Reset values
  localparam logic [15:0] SDFU_RST_CONFIG = 16'h0000;
  localparam logic [15:0] SDFU_RST_ZERO = 16'h0000;

  // Time base: 50 MHz clock, 16 Hz tick (half period of 8 Hz)
  localparam longint SDFU_CLK_HZ = 50000000;
  localparam longint SDFU_TICK_HZ = 16;
  localparam longint SDFU_TICK_CYCLES = SDFU_CLK_HZ / SDFU_TICK_HZ;
  // Tick divider per oscillator bit: half-period in 1/16 s ticks
  // bit0 2Hz, 1 1Hz, 2 0.5Hz, 3 1/64Hz, 4 1/8Hz, 5 4Hz, 6 8Hz
  localparam logic [9:0] SDFU_OSC_HALF [SDFU_OSC_COUNT] =
    '{10'h004, 10'h008, 10'h010, 10'h200, 10'h040, 10'h002, 10'h001};

  // AXI responses
  localparam logic [1:0] SDFU_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDFU_RESP_SLVERR = 2'h2;

  // Program sequencer states
  typedef enum logic [2:0] {
    SDFU_ST_STOP = 3'b000,
    SDFU_ST_COLD = 3'b001,
    SDFU_ST_WARM = 3'b010,
    SDFU_ST_LOAD = 3'b011,
    SDFU_ST_RUN = 3'b100
  } sdfu_state_t;

endpackage : sdfu_pkg

//--- sdfu_top.sv
`timescale 1ns/1ns
module sdfu_top
  import sdfu_pkg::*;
#(
  parameter longint TICK_CYCLES = SDFU_TICK_CYCLES,
  parameter int OUT_WIDTH = 16
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // AXI4-Lite write address and data
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // System events
  input wire logic NET_IRQ_I,
  input wire logic [3:0] ERR_CLASS_I,
  input wire logic [7:0] ERR_DETAIL_FATAL_I,
  input wire logic [7:0] ERR_DETAIL_SERIOUS_I,
  input wire logic [7:0] ERR_DETAIL_LIGHT_I,
  input wire logic [7:0] ERR_DETAIL_WARN_I,
  input wire logic [15:0] LOAD_PCT_I,
  input wire logic OVERRUN_I,
  input wire logic [15:0] OVERRUN_TASK_I,
  input wire logic [15:0] OVERRUN_LATE_I,
  input wire logic MISSED_CALL_I,
  // Bus and board status
  input wire logic BUS_NO_ERR_I,
  input wire logic BUS_INCLUDED_I,
  input wire logic CLOCK_VALID_I,
  input wire logic BATTERY_I,
  input wire logic [7:0] BUS_MODULES_I,
  // Run switch and memory state
  input wire logic RUN_SWITCH_I,
  input wire logic STORED_PROGRAM_I,
  input wire logic ERASE_DONE_I,
  // Sequencer and process outputs
  output logic PROGRAM_RUN_O,
  output logic ERASE_ALL_O,
  output logic ERASE_UNRETAINED_O,
  output logic LOAD_DEFAULTS_O,
  output logic LOAD_PROGRAM_O,
  output logic BUS_REINIT_O,
  output logic REORGANISATION_IN_PROGRESS_O,
  output logic [OUT_WIDTH-1:0] PROCESS_OUT_O
);
  import sdfu_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Oscillator bank
  sdfu_osc_if osc ();

  sdfu_osc_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_osc (
    .CLOCK_I(CLOCK_I),
    .SYS_RST_I(SYS_RST_I),
    .osc(osc)
  );

  //////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] config_word;
  logic net_irq;
  logic first_cycle;
  logic [15:0] missed_count;
  logic [15:0] ovr_task;
  logic [15:0] ovr_late;
  logic [7:0] bus_max;
  logic reorganisation_in_progress;
  logic [OUT_WIDTH-1:0] out_word;
  logic program_loaded;
  sdfu_state_t state;
  sdfu_state_t next_state;

  // Oscillator set routing
  wire osc_sel = config_word[SDFU_BIT_OSC_SEL];
  wire [6:0] osc_primary = osc_sel ? 7'h00 : osc.wave;
  wire [6:0] osc_alt = osc_sel ? osc.wave : 7'h00;
  // Error summary
  wire sum_err = |ERR_CLASS_I;
  wire [15:0] flag_primary = {first_cycle, ERR_CLASS_I, sum_err, net_irq,
                              2'b00, osc_primary};
  wire [15:0] detail_fs = {ERR_DETAIL_SERIOUS_I, ERR_DETAIL_FATAL_I};
  wire [15:0] detail_lw = {ERR_DETAIL_WARN_I, ERR_DETAIL_LIGHT_I};
  wire [15:0] bus_status = {bus_max, 4'h0, BATTERY_I, CLOCK_VALID_I,
                            BUS_INCLUDED_I, BUS_NO_ERR_I};

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data accepted in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;

  assign S_AXI_AWREADY_O = !aw_held && !bvalid;
  assign S_AXI_WREADY_O = !w_held && !bvalid;
  wire aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_fire = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire wr_go = aw_held && w_held && !bvalid;
  wire wr_lo = wr_go && w_strb[0];
  wire wr_hi = wr_go && w_strb[1];
  wire wr_known = (aw_addr <= SDFU_OFS_MODE) && (aw_addr[1:0] == 2'b00);
  wire wr_prim = wr_go && (aw_addr == SDFU_OFS_FLAG_PRIMARY);
  wire wr_cfg = wr_go && (aw_addr == SDFU_OFS_CONFIG);
  wire wr_ctl = wr_go && (aw_addr == SDFU_OFS_CONTROL);
  wire wr_mode = wr_go && (aw_addr == SDFU_OFS_MODE) && wr_lo;
  assign S_AXI_BVALID_O = bvalid;
  assign S_AXI_BRESP_O = bresp;

  // Capture write address and data
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (w_fire)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      bvalid <= 1'b0;
      bresp <= SDFU_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_known ? SDFU_RESP_OKAY : SDFU_RESP_SLVERR;
    end
    else if (S_AXI_BREADY_I)
      bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // Software-visible flags and configuration
  wire start_pulse = (state != SDFU_ST_RUN) && (next_state == SDFU_ST_RUN);

  // Network interrupt: event set wins over a software clear
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      net_irq <= 1'b0;
    else if (NET_IRQ_I)
      net_irq <= 1'b1;
    else if (wr_prim && wr_hi && !w_data[SDFU_BIT_NET_IRQ])
      net_irq <= 1'b0;
  end

  // First-cycle flag: cleared on every start, software may set it
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      first_cycle <= 1'b0;
    else if (start_pulse)
      first_cycle <= 1'b0;
    else if (wr_prim && wr_hi)
      first_cycle <= w_data[SDFU_BIT_FIRST_CYCLE];
  end

  // Configuration word and online-change control
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      config_word <= SDFU_RST_CONFIG;
      reorganisation_in_progress <= 1'b0;
    end
    else
    begin
      if (wr_cfg && wr_lo)
        config_word[7:0] <= w_data[7:0];
      if (wr_cfg && wr_hi)
        config_word[15:8] <= w_data[15:8];
      if (wr_ctl && wr_lo)
        reorganisation_in_progress <= w_data[0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Task monitoring and bus module high-water mark
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      missed_count <= SDFU_RST_ZERO;
      ovr_task <= SDFU_RST_ZERO;
      ovr_late <= SDFU_RST_ZERO;
      bus_max <= 8'h00;
    end
    else
    begin
      if (MISSED_CALL_I && missed_count != 16'hFFFF)
        missed_count <= missed_count + 16'h1;
      if (OVERRUN_I)
      begin
        ovr_task <= OVERRUN_TASK_I;
        ovr_late <= OVERRUN_LATE_I;
      end
      if (state == SDFU_ST_COLD || state == SDFU_ST_WARM)
        bus_max <= 8'h00;
      else if (BUS_MODULES_I > bus_max)
        bus_max <= BUS_MODULES_I;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Start sequencer: mode writes 1 = cold start, 2 = warm start
  wire cold_req = wr_mode && (w_data[1:0] == 2'h1);
  wire warm_req = wr_mode && (w_data[1:0] == 2'h2);

  always_comb
  begin
    next_state = state;
    case (state)
      SDFU_ST_STOP:
        if (cold_req)
          next_state = SDFU_ST_COLD;
        else if (warm_req)
          next_state = SDFU_ST_WARM;
        else if (RUN_SWITCH_I && program_loaded)
          next_state = SDFU_ST_RUN;
      SDFU_ST_COLD,
      SDFU_ST_WARM:
        if (ERASE_DONE_I)
          next_state = SDFU_ST_LOAD;
      SDFU_ST_LOAD:
        next_state = SDFU_ST_STOP;
      SDFU_ST_RUN:
        if (cold_req)
          next_state = SDFU_ST_COLD;
        else if (warm_req)
          next_state = SDFU_ST_WARM;
        else if (!RUN_SWITCH_I)
          next_state = SDFU_ST_STOP;
      default:
        next_state = SDFU_ST_STOP;
    endcase
  end

  // State and program presence
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      state <= SDFU_ST_STOP;
      program_loaded <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == SDFU_ST_COLD || state == SDFU_ST_WARM)
        program_loaded <= 1'b0;
      else if (state == SDFU_ST_LOAD)
        program_loaded <= STORED_PROGRAM_I;
    end
  end

  // Process outputs: only driven while running
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
      out_word <= '0;
    else if (next_state != SDFU_ST_RUN)
      out_word <= '0;
    else if (wr_ctl && wr_hi)
      out_word <= w_data[16 +: OUT_WIDTH];
  end

  // Sequencer strobes
  assign PROGRAM_RUN_O = (state == SDFU_ST_RUN);
  assign ERASE_ALL_O = (state == SDFU_ST_COLD);
  assign ERASE_UNRETAINED_O = (state == SDFU_ST_WARM);
  assign LOAD_DEFAULTS_O = (state == SDFU_ST_LOAD) && !STORED_PROGRAM_I;
  assign LOAD_PROGRAM_O = (state == SDFU_ST_LOAD) && STORED_PROGRAM_I;
  assign BUS_REINIT_O = (state == SDFU_ST_LOAD);
  assign REORGANISATION_IN_PROGRESS_O = reorganisation_in_progress;
  assign PROCESS_OUT_O = out_word;

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [15:0] rd_mux;
  logic rd_ok;

  assign S_AXI_ARREADY_O = !rvalid;
  wire ar_fire = S_AXI_ARVALID_I && !rvalid;

  // Read selection
  always_comb
  begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR_I)
      SDFU_OFS_FLAG_PRIMARY: rd_mux = flag_primary;
      SDFU_OFS_OSC_ALTERNATE: rd_mux = {9'h000, osc_alt};
      SDFU_OFS_DETAIL_FS: rd_mux = detail_fs;
      SDFU_OFS_DETAIL_LW: rd_mux = detail_lw;
      SDFU_OFS_LOAD_PCT: rd_mux = LOAD_PCT_I;
      SDFU_OFS_OVR_TASK: rd_mux = ovr_task;
      SDFU_OFS_OVR_LATE: rd_mux = ovr_late;
      SDFU_OFS_MISSED: rd_mux = missed_count;
      SDFU_OFS_BUS_STATUS: rd_mux = bus_status;
      SDFU_OFS_CONFIG: rd_mux = config_word;
      SDFU_OFS_CONTROL: rd_mux = {15'h0000, reorganisation_in_progress};
      SDFU_OFS_MODE: rd_mux = {13'h0000, state};
      default:
      begin
        rd_mux = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read data register
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= SDFU_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_mux};
      rresp <= rd_ok ? SDFU_RESP_OKAY : SDFU_RESP_SLVERR;
    end
    else if (S_AXI_RREADY_I)
      rvalid <= 1'b0;
  end

  assign S_AXI_RVALID_O = rvalid;
  assign S_AXI_RDATA_O = rdata;
  assign S_AXI_RRESP_O = rresp;

endmodule : sdfu_top

//--- tb_system_diag_flag_unit.sv
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
////////////////////////////////////////////////////////////////////////
module tb_system_diag_flag_unit;
  import sdfu_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} sdfu_exp_t;
  localparam logic [1:0] OK = SDFU_RESP_OKAY;
  // Oscillator half periods in 1/16 s ticks, bits 0..6
  localparam int HALF [7] = '{4, 8, 16, 512, 64, 2, 1};
  logic CLOCK_I = 1'b0, SYS_RST_I = 1'b1;
  logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0;
  logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O;
  logic [3:0] S_AXI_WSTRB_I = '0, ERR_CLASS_I = '0, cls, b;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
  logic S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic NET_IRQ_I = 0, OVERRUN_I = 0, MISSED_CALL_I = 0, BUS_NO_ERR_I = 0;
  logic BUS_INCLUDED_I = 0, CLOCK_VALID_I = 0, BATTERY_I = 0;
  logic RUN_SWITCH_I = 0, STORED_PROGRAM_I = 0, ERASE_DONE_I = 0;
  logic [7:0] ERR_DETAIL_FATAL_I = '0, ERR_DETAIL_SERIOUS_I = '0;
  logic [7:0] ERR_DETAIL_LIGHT_I = '0, ERR_DETAIL_WARN_I = '0;
  logic [7:0] BUS_MODULES_I = '0, a;
  logic [15:0] LOAD_PCT_I = '0, OVERRUN_TASK_I = '0, OVERRUN_LATE_I = '0;
  logic [15:0] PROCESS_OUT_O, last_po = '0;
  logic PROGRAM_RUN_O, ERASE_ALL_O, ERASE_UNRETAINED_O, LOAD_DEFAULTS_O;
  logic LOAD_PROGRAM_O, BUS_REINIT_O, REORGANISATION_IN_PROGRESS_O;
  logic [31:0] v, v2, m, dt;
  int error_cnt = 0, checks = 0, cyc = 0, t0;
  sdfu_exp_t rq[$], e;
  logic [1:0] bq[$];
  logic [15:0] pq[$];

  sdfu_top #(.TICK_CYCLES(4), .OUT_WIDTH(16)) dut (
    .CLOCK_I, .SYS_RST_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
    .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I, .S_AXI_WVALID_I,
    .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
    .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
    .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .NET_IRQ_I,
    .ERR_CLASS_I, .ERR_DETAIL_FATAL_I, .ERR_DETAIL_SERIOUS_I,
    .ERR_DETAIL_LIGHT_I, .ERR_DETAIL_WARN_I, .LOAD_PCT_I, .OVERRUN_I,
    .OVERRUN_TASK_I, .OVERRUN_LATE_I, .MISSED_CALL_I, .BUS_NO_ERR_I,
    .BUS_INCLUDED_I, .CLOCK_VALID_I, .BATTERY_I, .BUS_MODULES_I,
    .RUN_SWITCH_I, .STORED_PROGRAM_I, .ERASE_DONE_I, .PROGRAM_RUN_O,
    .ERASE_ALL_O, .ERASE_UNRETAINED_O, .LOAD_DEFAULTS_O, .LOAD_PROGRAM_O,
    .BUS_REINIT_O, .REORGANISATION_IN_PROGRESS_O, .PROCESS_OUT_O);

  ////////////////////////////////////////////////////////////////////////
  // Clock and cycle count
  initial
  begin
    forever #10 CLOCK_I = ~CLOCK_I;
  end
  always @(posedge CLOCK_I) cyc <= cyc + 1;

  // Compare each answer with the oldest note
  always @(posedge CLOCK_I)
  begin
    if (S_AXI_RVALID_O && S_AXI_RREADY_I)
    begin
      e = rq.pop_front();
      `CHK(S_AXI_RDATA_O & e.m, e.d & e.m)
      `CHK(S_AXI_RRESP_O, e.r)
    end
    // Notes are taken off once, so a mismatch cannot drop a second one
    if (S_AXI_BVALID_O && S_AXI_BREADY_I)
    begin
      e.r = bq.pop_front();
      `CHK(S_AXI_BRESP_O, e.r)
    end
    if (!SYS_RST_I && PROCESS_OUT_O !== last_po)
    begin
      e.d[15:0] = pq.pop_front();
      `CHK(PROCESS_OUT_O, e.d[15:0])
      last_po = PROCESS_OUT_O;
    end
  end

  task summarize;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // A wait that used up its bound ends the run
  task tmo(input int n);
    if (n >= 200)
    begin
      error_cnt++;
      summarize();
    end
  endtask : tmo

  // Read one word, noting what it should hold
  task rd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] mk,
    input logic [1:0] r, output logic [31:0] q);
    int n;
    rq.push_back('{d, mk, r});
    S_AXI_ARADDR_I <= ad;
    S_AXI_ARVALID_I <= 1'b1;
    @(posedge CLOCK_I);
    for (n = 0; n < 200 && !S_AXI_ARREADY_O; n++) @(posedge CLOCK_I);
    tmo(n);
    S_AXI_ARVALID_I <= 1'b0;
    @(posedge CLOCK_I);
    for (n = 0; n < 200 && !S_AXI_RVALID_O; n++) @(posedge CLOCK_I);
    tmo(n);
    q = S_AXI_RDATA_O;
  endtask : rd

  // Write one word; address and data offered together
  task wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int n;
    logic aw;
    logic w;
    bq.push_back(r);
    aw = 1;
    w = 1;
    S_AXI_AWADDR_I <= ad;
    S_AXI_WDATA_I <= d;
    S_AXI_WSTRB_I <= s;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    for (n = 0; n < 200 && (aw || w); n++)
    begin
      @(posedge CLOCK_I);
      if (aw && S_AXI_AWREADY_O)
      begin
        aw = 0;
        S_AXI_AWVALID_I <= 1'b0;
      end
      if (w && S_AXI_WREADY_O)
      begin
        w = 0;
        S_AXI_WVALID_I <= 1'b0;
      end
    end
    tmo(n);
    for (n = 0; n < 200 && !S_AXI_BVALID_O; n++) @(posedge CLOCK_I);
    tmo(n);
  endtask : wr

  // Cold or warm start, then finish the erase
  task boot(input logic [31:0] md);
    wr(SDFU_OFS_MODE, md, 4'h1, OK);
    repeat (3) @(posedge CLOCK_I);
    ERASE_DONE_I <= 1'b1;
    repeat (3) @(posedge CLOCK_I);
    ERASE_DONE_I <= 1'b0;
  endtask : boot

  task wait_run(input logic want);
    int n;
    for (n = 0; n < 200 && PROGRAM_RUN_O !== want; n++) @(posedge CLOCK_I);
    tmo(n);
  endtask : wait_run

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(49168));
    repeat (5) @(posedge CLOCK_I);
    SYS_RST_I <= 1'b0;
    S_AXI_BREADY_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    @(posedge CLOCK_I);
    rd(SDFU_OFS_CONFIG, 0, '1, OK, v);
    rd(SDFU_OFS_MODE, 32'(SDFU_ST_STOP), '1, OK, v);
    rd(8'h40, 0, '1, SDFU_RESP_SLVERR, v);
    rd(8'h02, 0, '1, SDFU_RESP_SLVERR, v);
    wr(8'h40, 32'h1234, 4'hF, SDFU_RESP_SLVERR);
    // Both oscillator sets, each bit over one half period
    for (int s = 0; s < 2; s++)
    begin
      wr(SDFU_OFS_CONFIG, 32'(s) << 15, 4'h3, OK);
      a = s ? SDFU_OFS_OSC_ALTERNATE : SDFU_OFS_FLAG_PRIMARY;
      rd(s ? SDFU_OFS_FLAG_PRIMARY : SDFU_OFS_OSC_ALTERNATE, 0, 32'h7F, OK,
        v);
      for (int i = 0; i < 7; i++)
      begin
        m = 0;
        for (int j = 0; j < 7; j++) m[j] = HALF[j] <= HALF[i];
        t0 = cyc;
        rd(a, 0, 0, OK, v);
        while (cyc < t0 + 4 * HALF[i]) @(posedge CLOCK_I);
        rd(a, v ^ (32'h1 << i), m, OK, v2);
      end
    end
    // Sticky network interrupt
    NET_IRQ_I <= 1'b1;
    @(posedge CLOCK_I);
    NET_IRQ_I <= 1'b0;
    rd(SDFU_OFS_FLAG_PRIMARY, 32'h200, 32'h200, OK, v);
    rd(SDFU_OFS_FLAG_PRIMARY, 32'h200, 32'h200, OK, v);
    wr(SDFU_OFS_FLAG_PRIMARY, 0, 4'h2, OK);
    rd(SDFU_OFS_FLAG_PRIMARY, 0, 32'h200, OK, v);
    // Error classes and details
    for (int c = 0; c < 6; c++)
    begin
      cls = (c < 4) ? 4'(1 << c) : (c == 4) ? 4'h0 : 4'($urandom);
      dt = $urandom;
      ERR_CLASS_I <= cls;
      {ERR_DETAIL_WARN_I, ERR_DETAIL_LIGHT_I} <= dt[31:16];
      {ERR_DETAIL_SERIOUS_I, ERR_DETAIL_FATAL_I} <= dt[15:0];
      @(posedge CLOCK_I);
      rd(SDFU_OFS_FLAG_PRIMARY, 32'({cls, |cls}) << 10, 32'h7C00, OK,
        v);
      rd(SDFU_OFS_DETAIL_FS, {16'h0, dt[15:0]}, '1, OK, v);
      rd(SDFU_OFS_DETAIL_LW, {16'h0, dt[31:16]}, '1, OK, v);
    end
    // Load, overrun capture and missed calls
    dt = $urandom;
    LOAD_PCT_I <= dt[15:0];
    OVERRUN_TASK_I <= dt[31:16];
    OVERRUN_LATE_I <= ~dt[15:0];
    OVERRUN_I <= 1'b1;
    MISSED_CALL_I <= 1'b1;
    @(posedge CLOCK_I);
    OVERRUN_I <= 1'b0;
    OVERRUN_TASK_I <= 16'h0;
    OVERRUN_LATE_I <= 16'h0;
    repeat (2) @(posedge CLOCK_I);
    MISSED_CALL_I <= 1'b0;
    @(posedge CLOCK_I);
    rd(SDFU_OFS_LOAD_PCT, {16'h0, dt[15:0]}, '1, OK, v);
    rd(SDFU_OFS_OVR_TASK, {16'h0, dt[31:16]}, '1, OK, v);
    rd(SDFU_OFS_OVR_LATE, {16'h0, ~dt[15:0]}, '1, OK, v);
    rd(SDFU_OFS_MISSED, 32'h3, '1, OK, v);
    // Bus status and module maximum
    b = 4'($urandom);
    {BATTERY_I, CLOCK_VALID_I, BUS_INCLUDED_I, BUS_NO_ERR_I} <= b;
    BUS_MODULES_I <= 8'h05;
    @(posedge CLOCK_I);
    BUS_MODULES_I <= 8'hE9;
    @(posedge CLOCK_I);
    BUS_MODULES_I <= 8'h33;
    repeat (2) @(posedge CLOCK_I);
    rd(SDFU_OFS_BUS_STATUS, {16'h0, 8'hE9, 4'h0, b}, '1, OK, v);
    // Cold start with no stored program: run switch must not start
    boot(32'h1);
    RUN_SWITCH_I <= 1'b1;
    repeat (4) @(posedge CLOCK_I);
    rd(SDFU_OFS_MODE, 32'(SDFU_ST_STOP), '1, OK, v);
    // Cold start with a program, run, first-cycle flag read clear then set by software
    RUN_SWITCH_I <= 1'b0;
    STORED_PROGRAM_I <= 1'b1;
    boot(32'h1);
    RUN_SWITCH_I <= 1'b1;
    wait_run(1'b1);
    rd(SDFU_OFS_FLAG_PRIMARY, 0, 32'h8000, OK, v);
    wr(SDFU_OFS_FLAG_PRIMARY, 32'h8000, 4'h2, OK);
    rd(SDFU_OFS_FLAG_PRIMARY, 32'h8000, 32'h8000, OK, v);
    // Online change: reorganisation shown, no further change sent meanwhile
    wr(SDFU_OFS_CONTROL, 32'h1, 4'h1, OK);
    `CHK(REORGANISATION_IN_PROGRESS_O, 1'b1)
    rd(SDFU_OFS_CONTROL, 32'h1, '1, OK, v);
    // Output lanes and reorganisation end share one full-word write
    pq.push_back(16'hA5C3);
    wr(SDFU_OFS_CONTROL, 32'hA5C30000, 4'hF, OK);
    `CHK(REORGANISATION_IN_PROGRESS_O, 1'b0)
    pq.push_back(16'h0);
    RUN_SWITCH_I <= 1'b0;
    wait_run(1'b0);
    wr(SDFU_OFS_CONTROL, 32'h5A3C0000, 4'hF, OK);
    // Warm start: module maximum rebuilt, first-cycle flag cleared again
    BUS_MODULES_I <= 8'h02;
    boot(32'h2);
    rd(SDFU_OFS_BUS_STATUS, {16'h0, 8'h02, 4'h0, b}, '1, OK, v);
    RUN_SWITCH_I <= 1'b1;
    wait_run(1'b1);
    rd(SDFU_OFS_FLAG_PRIMARY, 0, 32'h8000, OK, v);
    RUN_SWITCH_I <= 1'b0;
    wait_run(1'b0);
    repeat (4) @(posedge CLOCK_I);
    // Every expected output change must have been seen
    `CHK(pq.size(), 0)
    summarize();
  end
endmodule : tb_system_diag_flag_unit
